// ===== nalf_pkg.sv
// Constants, types and carriers for the nibble ALU flag block
// Behaviour
// RULE1: First operand latches into holding register A, second into B, before evaluation.
// RULE2: ALU flags and status word flags are one storage; writes show immediately.
// RULE3: Compare flag clear: arithmetic sets zero on 0000B result, else clears.
// RULE4: Compare flag set: zero result keeps zero flag, nonzero result clears it.
// RULE5: Arithmetic sets carry on carry out or borrow, clears it otherwise.
// RULE6: Add-with-carry and subtract-with-borrow inject carry flag as lowest carry input.
// RULE7: Rotate through carry puts old carry in bit 3, bit 0 into carry.
// RULE8: Only arithmetic and rotate through carry may change the carry flag.
// RULE9: Compare flag set suppresses arithmetic write-back; flags still update.
// RULE10: Any bit evaluation clears the compare flag.
// RULE11: Compare flag never affects comparisons, logical operations or rotations.
// RULE12: Decimal flag one gives BCD arithmetic; zero gives plain 4-bit binary.
// RULE13: Decimal flag never affects logic, bit tests, comparisons or rotations.
// RULE14: Binary addition stores sum modulo sixteen; carry for sums of 16 upward.
// RULE15: BCD sums 10 to 19 give carry and digit equal to sum minus ten.
// RULE16: BCD sums 20 upward, subtractions outside -10..9 store nibble 1010B or above.
// RULE17: Logical operations leave zero and carry flags unchanged.
// RULE18: Bit and comparison evaluations decide skip of next instruction, no write-back.
// RULE19: Add and subtract without carry use zero carry input, ignore carry flag.
package nalf_pkg;

  localparam int NIB_W = 4;

  // Nibble and arithmetic constants
  localparam logic [3:0] NIB_ZERO   = 4'h0;
  localparam logic [4:0] BCD_TEN    = 5'h0a;
  localparam logic [4:0] BCD_TWENTY = 5'h14;
  localparam logic [4:0] SUB_NEG10  = 5'h16;
  localparam logic [1:0] BCD_HI     = 2'h3;
  localparam logic [1:0] BCD_ADJ    = 2'h2;

  // Register map, byte addresses
  localparam logic [7:0] ADDR_PSW  = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLV  = 2'h2;

  // Status word field positions
  localparam int PSW_Z       = 0;
  localparam int PSW_CARRY   = 1;
  localparam int PSW_NOSTORE = 2;
  localparam int PSW_BCD     = 3;
  localparam logic [3:0] PSW_RST = 4'h0;

  // Instruction classes seen by the ALU
  typedef enum logic [3:0] {
    OP_ADD        = 4'h0,
    OP_ADD_CARRY  = 4'h1,
    OP_SUB        = 4'h2,
    OP_SUB_BORROW = 4'h3,
    OP_AND        = 4'h4,
    OP_OR         = 4'h5,
    OP_XOR        = 4'h6,
    OP_BITT       = 4'h7,
    OP_BITF       = 4'h8,
    OP_CMPE       = 4'h9,
    OP_CMPN       = 4'ha,
    OP_ROT_CARRY  = 4'hb
  } nalf_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } nalf_state_t;

  // Request from the sequencer
  typedef struct packed {
    nalf_op_t        op;
    logic [3:0]      opa;
    logic [3:0]      opb;
  } nalf_req_t;

  // Result back to register file and sequencer
  typedef struct packed {
    logic [3:0]      data;
    logic            wb;
    logic            skip;
  } nalf_res_t;

endpackage

// ===== nalf_arith.sv
// Binary and BCD nibble adder/subtractor
`timescale 1ns/100ps
module nalf_arith (
  input  wire logic [3:0] opa,
  input  wire logic [3:0] opb,
  input  wire logic       cin,
  input  wire logic       sub,
  input  wire logic       bcd,
  output logic      [3:0] res,
  output logic            cout
);

  // Decimal correction of a 5-bit sum, {carry, digit}
  function automatic logic [4:0] bcd_add_fix(input logic [4:0] s);
    logic [4:0] m;
    m = 5'(s - nalf_pkg::BCD_TEN);
    if (s < nalf_pkg::BCD_TEN) begin
      bcd_add_fix = {1'b0, s[3:0]};
    end else if (s < nalf_pkg::BCD_TWENTY) begin
      bcd_add_fix = {1'b1, m[3:0]};
    end else begin
      unique case (s)
        5'h1c:   bcd_add_fix = 5'h1a;
        5'h1d:   bcd_add_fix = 5'h1b;
        5'h1e:   bcd_add_fix = 5'h1c;
        5'h1f:   bcd_add_fix = 5'h1d;
        default: bcd_add_fix = {1'b1, nalf_pkg::BCD_HI, 2'(s[1:0] + nalf_pkg::BCD_ADJ)};
      endcase
    end
  endfunction

  // Decimal correction of a 5-bit signed difference
  function automatic logic [4:0] bcd_sub_fix(input logic [4:0] r);
    logic [4:0] p;
    p = 5'(r + nalf_pkg::BCD_TEN);
    if (!r[4] && r < nalf_pkg::BCD_TEN) begin
      bcd_sub_fix = {1'b0, r[3:0]};
    end else if (r[4] && r >= nalf_pkg::SUB_NEG10) begin
      bcd_sub_fix = {1'b1, p[3:0]};
    end else begin
      bcd_sub_fix = {1'b1, nalf_pkg::BCD_HI, 2'(r[1:0] + nalf_pkg::BCD_ADJ)};
    end
  endfunction

  logic [4:0] bin_sum;
  logic [4:0] bin_dif;
  logic [4:0] bcd_sum;
  logic [4:0] bcd_dif;
  logic [4:0] pick;

  // RULE14 binary sum modulo sixteen
  assign bin_sum = 5'({1'b0, opa} + {1'b0, opb} + {4'h0, cin});
  assign bin_dif = 5'({1'b0, opa} - {1'b0, opb} - {4'h0, cin});
  // RULE15 RULE16 decimal correction
  assign bcd_sum = bcd_add_fix(bin_sum);
  assign bcd_dif = bcd_sub_fix(bin_dif);
  // RULE12 mode select
  assign pick = bcd ? (sub ? bcd_dif : bcd_sum) : (sub ? bin_dif : bin_sum);
  assign res  = pick[3:0];
  assign cout = pick[4];

endmodule

// ===== nalf_core.sv
// Nibble ALU with status flags, operand latches and AXI4-Lite status word access
//
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
module nalf_core #(
  parameter int ADDR_W = 8
) (
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire nalf_pkg::nalf_req_t req,
  input  wire logic              req_valid,
  output logic                   req_ready,
  output nalf_pkg::nalf_res_t    res,
  output logic                   res_valid,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // Operation class decode, used by execute and checks
  function automatic logic is_arith(input nalf_pkg::nalf_op_t o);
    is_arith = (o == nalf_pkg::OP_ADD) || (o == nalf_pkg::OP_ADD_CARRY) ||
               (o == nalf_pkg::OP_SUB) || (o == nalf_pkg::OP_SUB_BORROW);
  endfunction

  function automatic logic is_bit(input nalf_pkg::nalf_op_t o);
    is_bit = (o == nalf_pkg::OP_BITT) || (o == nalf_pkg::OP_BITF);
  endfunction

  nalf_pkg::nalf_state_t state;
  nalf_pkg::nalf_state_t next_state;
  nalf_pkg::nalf_op_t    op_q;
  logic [3:0]            opa_q;
  logic [3:0]            opb_q;
  logic [3:0]            psw;
  logic [3:0]            next_psw;
  logic                  z_flag;
  logic                  carry_flag;
  logic                  compare_no_store_flag;
  logic                  bcd_flag;

  // Status word bits are the ALU flags themselves
  assign z_flag                = psw[nalf_pkg::PSW_Z];
  assign carry_flag            = psw[nalf_pkg::PSW_CARRY];
  assign compare_no_store_flag = psw[nalf_pkg::PSW_NOSTORE];
  assign bcd_flag              = psw[nalf_pkg::PSW_BCD];

  // Handshake and execute strobe
  logic req_take;
  logic exec;
  assign req_ready  = (state == nalf_pkg::ST_IDLE);
  assign req_take   = req_valid && req_ready;
  assign exec       = (state == nalf_pkg::ST_EXEC);
  assign next_state = req_take ? nalf_pkg::ST_EXEC : nalf_pkg::ST_IDLE;

  // Sequencer state
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= nalf_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // RULE1 operand holding registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      op_q  <= nalf_pkg::OP_ADD;
      opa_q <= nalf_pkg::NIB_ZERO;
      opb_q <= nalf_pkg::NIB_ZERO;
    end else if (req_take) begin
      op_q  <= req.op;
      opa_q <= req.opa;
      opb_q <= req.opb;
    end
  end

  // Operation decode on held operation
  logic op_arith;
  logic op_withc;
  logic op_sub;
  logic op_bit;
  logic op_cmp;
  logic op_logic;
  logic op_rotate_right_through_carry;
  assign op_arith = is_arith(op_q);
  assign op_withc = (op_q == nalf_pkg::OP_ADD_CARRY) || (op_q == nalf_pkg::OP_SUB_BORROW);
  assign op_sub   = (op_q == nalf_pkg::OP_SUB) || (op_q == nalf_pkg::OP_SUB_BORROW);
  assign op_bit   = is_bit(op_q);
  assign op_cmp   = (op_q == nalf_pkg::OP_CMPE) || (op_q == nalf_pkg::OP_CMPN);
  assign op_logic = (op_q == nalf_pkg::OP_AND) || (op_q == nalf_pkg::OP_OR) || (op_q == nalf_pkg::OP_XOR);
  assign op_rotate_right_through_carry  = (op_q == nalf_pkg::OP_ROT_CARRY);

  // RULE6 RULE19 carry input select
  logic ar_cin;
  assign ar_cin = op_withc ? carry_flag : 1'b0;

  logic [3:0] ar_res;
  logic       ar_cout;
  nalf_arith u_arith (
    .opa  (opa_q),
    .opb  (opb_q),
    .cin  (ar_cin),
    .sub  (op_sub),
    .bcd  (bcd_flag),
    .res  (ar_res),
    .cout (ar_cout)
  );

  // RULE13 RULE11 logic, tests and rotate ignore mode flags
  logic [3:0] lg_res;
  logic [3:0] rot_res;
  logic       bit_hit;
  logic       cmp_hit;
  assign lg_res  = (op_q == nalf_pkg::OP_AND) ? (opa_q & opb_q) :
                   (op_q == nalf_pkg::OP_OR)  ? (opa_q | opb_q) : (opa_q ^ opb_q);
  // RULE7 rotate right through carry
  assign rot_res = {carry_flag, opa_q[3:1]};
  assign bit_hit = (op_q == nalf_pkg::OP_BITT) ? ((opa_q & opb_q) == opb_q)
                                               : ((opa_q & opb_q) == nalf_pkg::NIB_ZERO);
  assign cmp_hit = (op_q == nalf_pkg::OP_CMPE) ? (opa_q == opb_q) : (opa_q != opb_q);

  // Result assembly for the execute cycle
  nalf_pkg::nalf_res_t next_res;
  logic [3:0]          nr_data;
  logic                nr_wb;
  logic                nr_skip;
  // RULE9 RULE18 write-back and skip decision
  assign nr_data  = op_arith ? ar_res : (op_rotate_right_through_carry ? rot_res : (op_logic ? lg_res : nalf_pkg::NIB_ZERO));
  assign nr_wb    = (op_arith && !compare_no_store_flag) || op_logic || op_rotate_right_through_carry;
  assign nr_skip  = (op_bit && bit_hit) || (op_cmp && cmp_hit);
  assign next_res = {nr_data, nr_wb, nr_skip};

  // Result register and valid pulse
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      res       <= '0;
      res_valid <= 1'b0;
    end else begin
      res_valid <= exec;
      if (exec) begin
        res <= next_res;
      end
    end
  end

  // AXI4-Lite write side
  logic              aw_full;
  logic              w_full;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              wr_go;
  logic              psw_wr;
  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready  = !w_full && !s_axi_bvalid;
  assign wr_go         = aw_full && w_full && !s_axi_bvalid;
  assign psw_wr        = wr_go && (aw_addr == ADDR_W'(nalf_pkg::ADDR_PSW)) && w_strb[0];

  // Address and data latched independently
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      aw_full      <= 1'b0;
      w_full       <= 1'b0;
      aw_addr      <= '0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= nalf_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_full      <= 1'b0;
        w_full       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr == ADDR_W'(nalf_pkg::ADDR_PSW)) ? nalf_pkg::RESP_OKAY : nalf_pkg::RESP_SLV;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // RULE2 one flag store for bus and ALU; ALU update wins
  // RULE17 logic ops fall through, zero and carry kept
  always_comb begin
    next_psw = psw;
    if (psw_wr) begin
      next_psw = w_data[3:0];
    end
    if (exec) begin
      if (op_arith) begin
        // RULE5 carry or borrow out
        next_psw[nalf_pkg::PSW_CARRY] = ar_cout;
        // RULE3 RULE4 zero flag, chained when compare set
        if (compare_no_store_flag) begin
          next_psw[nalf_pkg::PSW_Z] = (ar_res == nalf_pkg::NIB_ZERO) ? z_flag : 1'b0;
        end else begin
          next_psw[nalf_pkg::PSW_Z] = (ar_res == nalf_pkg::NIB_ZERO);
        end
      end
      // RULE8 RULE7 rotate loads bit 0 into carry
      if (op_rotate_right_through_carry) begin
        next_psw[nalf_pkg::PSW_CARRY] = opa_q[0];
      end
      // RULE10 bit test clears compare flag
      if (op_bit) begin
        next_psw[nalf_pkg::PSW_NOSTORE] = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      psw <= nalf_pkg::PSW_RST;
    end else begin
      psw <= next_psw;
    end
  end

  // AXI4-Lite read side
  logic        rd_psw;
  logic        rd_stat;
  logic [31:0] rd_word;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_psw        = (s_axi_araddr == ADDR_W'(nalf_pkg::ADDR_PSW));
  assign rd_stat       = (s_axi_araddr == ADDR_W'(nalf_pkg::ADDR_STAT));
  assign rd_word       = rd_psw  ? {28'h0, psw} :
                         rd_stat ? {24'h0, exec, res.skip, res.wb, 1'b0, res.data} : 32'h0;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= nalf_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= (rd_psw || rd_stat) ? nalf_pkg::RESP_OKAY : nalf_pkg::RESP_SLV;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks on the flag and result behaviour
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  logic [4:0] add_sum;
  assign add_sum = 5'({1'b0, opa_q} + {1'b0, opb_q});

  property p_latch;
    req_take |=> (opa_q == $past(req.opa)) && (opb_q == $past(req.opb)) && exec;
  endproperty
  a_latch: assert property (p_latch) else $error("operands not held"); // RULE1

  property p_psw_wr;
    psw_wr && !exec |=> psw == $past(w_data[3:0]);
  endproperty
  a_psw_wr: assert property (p_psw_wr) else $error("status word write lost"); // RULE2

  property p_zero_set;
    exec && op_arith && !compare_no_store_flag |=> z_flag == ($past(ar_res) == nalf_pkg::NIB_ZERO);
  endproperty
  a_zero_set: assert property (p_zero_set) else $error("zero flag wrong"); // RULE3

  property p_zero_chain;
    exec && op_arith && compare_no_store_flag |=>
      z_flag == (($past(ar_res) == nalf_pkg::NIB_ZERO) && $past(z_flag));
  endproperty
  a_zero_chain: assert property (p_zero_chain) else $error("chained zero wrong"); // RULE4

  property p_carry;
    exec && op_arith |=> carry_flag == $past(ar_cout) && res_valid;
  endproperty
  a_carry: assert property (p_carry) else $error("carry not taken"); // RULE5

  property p_rotate_right_through_carry;
    exec && op_rotate_right_through_carry |=> res.data[3] == $past(carry_flag) && carry_flag == $past(opa_q[0]) && res.wb;
  endproperty
  a_rotate_right_through_carry: assert property (p_rotate_right_through_carry) else $error("rotate wrong"); // RULE7

  property p_cy_hold;
    exec && !op_arith && !op_rotate_right_through_carry && !psw_wr |=> $stable(carry_flag) && $stable(z_flag);
  endproperty
  a_cy_hold: assert property (p_cy_hold) else $error("carry changed"); // RULE8

  property p_nostore;
    exec && op_arith && compare_no_store_flag |=> res_valid && !res.wb;
  endproperty
  a_nostore: assert property (p_nostore) else $error("stored under compare"); // RULE9

  property p_bit_clr;
    exec && op_bit |=> !compare_no_store_flag && !res.wb;
  endproperty
  a_bit_clr: assert property (p_bit_clr) else $error("compare flag not cleared"); // RULE10

  property p_bin_add;
    exec && op_q == nalf_pkg::OP_ADD && !bcd_flag |=> res.data == $past(add_sum[3:0]) && carry_flag == $past(add_sum[4]);
  endproperty
  a_bin_add: assert property (p_bin_add) else $error("binary sum wrong"); // RULE14

  property p_bcd_add;
    exec && op_q == nalf_pkg::OP_ADD && bcd_flag && add_sum >= nalf_pkg::BCD_TEN && add_sum < nalf_pkg::BCD_TWENTY
      |=> carry_flag && res.data == $past(4'(add_sum - nalf_pkg::BCD_TEN));
  endproperty
  a_bcd_add: assert property (p_bcd_add) else $error("decimal digit wrong"); // RULE15

  property p_logic_keep;
    exec && op_logic && !psw_wr |=> $stable(carry_flag) && $stable(z_flag) && res.wb;
  endproperty
  a_logic_keep: assert property (p_logic_keep) else $error("logic op changed flags"); // RULE17

  property p_skip;
    exec && op_q == nalf_pkg::OP_CMPE |=> res.skip == ($past(opa_q) == $past(opb_q)) && !res.wb;
  endproperty
  a_skip: assert property (p_skip) else $error("compare skip wrong"); // RULE18

  property p_add_with_carry;
    exec && op_q == nalf_pkg::OP_ADD_CARRY && !bcd_flag |=>
      res.data == $past(4'(opa_q + opb_q + {3'h0, carry_flag}));
  endproperty
  a_add_with_carry: assert property (p_add_with_carry) else $error("carry input not used"); // RULE6

  c_rotate_right_through_carry:  cover property (exec && op_rotate_right_through_carry);
  c_chain: cover property (exec && op_arith && compare_no_store_flag);
  c_bcd:   cover property (exec && op_arith && bcd_flag && ar_cout);
  c_skip:  cover property (res_valid && res.skip);

endmodule

// ===== nalf_seq_model.sv
// Sequencer side model that issues one instruction and captures its result
`timescale 1ns/100ps
module nalf_seq_model (
  input  wire logic                core_clk,
  input  wire logic                sys_rst,
  input  wire logic                go,
  input  wire logic [3:0]          dly,
  input  wire nalf_pkg::nalf_req_t cmd,
  output nalf_pkg::nalf_req_t      req,
  output logic                     req_valid,
  input  wire logic                req_ready,
  input  wire nalf_pkg::nalf_res_t res,
  input  wire logic                res_valid,
  output nalf_pkg::nalf_res_t      got,
  output logic                     got_valid
);
  logic [3:0] wait_cnt;
  logic       armed;

  // Launch after a chosen lag, hold until taken, capture the result pulse
  always_ff @(posedge core_clk) begin
    got_valid <= 1'b0;
    if (sys_rst) begin
      req_valid <= 1'b0;
      armed     <= 1'b0;
      wait_cnt  <= 4'h0;
      req       <= '0;
      got       <= '0;
    end else begin
      if (go) begin
        armed    <= 1'b1;
        wait_cnt <= dly;
        req      <= cmd;
      end else if (armed && wait_cnt != 4'h0) begin
        wait_cnt <= wait_cnt - 4'h1;
      end else if (armed) begin
        req_valid <= 1'b1;
        armed     <= 1'b0;
      end
      if (req_valid && req_ready) begin
        req_valid <= 1'b0;
        req       <= ~req;
      end
      if (res_valid) begin
        got       <= res;
        got_valid <= 1'b1;
      end
    end
  end
endmodule

// ===== nalf_tb.sv
// Self-checking testbench for the nibble ALU flag block
`timescale 1ns/100ps
module tb;
  logic                core_clk;
  logic                sys_rst;
  logic                go;
  logic [3:0]          dly;
  nalf_pkg::nalf_req_t cmd;
  nalf_pkg::nalf_req_t req;
  logic                req_valid;
  logic                req_ready;
  nalf_pkg::nalf_res_t res;
  logic                res_valid;
  nalf_pkg::nalf_res_t got;
  logic                got_valid;
  logic [7:0]          s_axi_awaddr;
  logic                s_axi_awvalid;
  logic                s_axi_awready;
  logic [31:0]         s_axi_wdata;
  logic [3:0]          s_axi_wstrb;
  logic                s_axi_wvalid;
  logic                s_axi_wready;
  logic [1:0]          s_axi_bresp;
  logic                s_axi_bvalid;
  logic                s_axi_bready;
  logic [7:0]          s_axi_araddr;
  logic                s_axi_arvalid;
  logic                s_axi_arready;
  logic [31:0]         s_axi_rdata;
  logic [1:0]          s_axi_rresp;
  logic                s_axi_rvalid;
  logic                s_axi_rready;
  int                  err_count;
  int                  cmp_count;
  logic [31:0]         rd;
  logic [1:0]          rsp;
  nalf_pkg::nalf_res_t o;
  nalf_pkg::nalf_req_t r;
  // Vector nibbles: op, a, b, flags in, data, flags out, {wb, skip}
  logic [27:0]         vecs [28] = '{
    28'h0790032, 28'h0872f02, 28'h1872032, 28'h0458982,
    28'h09988a2, 28'h05580b2, 28'h0ff8ca2, 28'h19aaea2,
    28'h2350e22, 28'h2552012, 28'h3542012, 28'h23588a2,
    28'h20f8fa2, 28'h0004040, 28'h0005050, 28'h0105140,
    28'h0884060, 28'h4caf8f2, 28'h5340702, 28'h6f54a42,
    28'h7e6f0b1, 28'h8e14001, 28'h7124000, 28'h955c0c1,
    28'ha55c0c0, 28'hb502a22, 28'hb40eac2, 28'hb301132
  };

  nalf_core dut_u (
    .core_clk(core_clk), .sys_rst(sys_rst), .req(req), .req_valid(req_valid), .req_ready(req_ready),
    .res(res), .res_valid(res_valid), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );

  nalf_seq_model model_u (
    .core_clk(core_clk), .sys_rst(sys_rst), .go(go), .dly(dly), .cmd(cmd), .req(req),
    .req_valid(req_valid), .req_ready(req_ready), .res(res), .res_valid(res_valid),
    .got(got), .got_valid(got_valid)
  );

  // Clock at 20 MHz
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic tally_and_finish();
    if (err_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Write with both channels offered together; handshakes seen before the edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    logic aw_hs;
    logic w_hs;
    logic b_hs;
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hf;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    b_hs = 1'b0;
    while (!b_hs) begin
      @(negedge core_clk);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs  = s_axi_wvalid && s_axi_wready;
      b_hs  = s_axi_bvalid && s_axi_bready;
      rs    = s_axi_bresp;
      @(posedge core_clk);
      if (aw_hs) s_axi_awvalid <= 1'b0;
      if (w_hs) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    logic ar_hs;
    logic r_hs;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    r_hs = 1'b0;
    while (!r_hs) begin
      @(negedge core_clk);
      ar_hs = s_axi_arvalid && s_axi_arready;
      r_hs  = s_axi_rvalid && s_axi_rready;
      d     = s_axi_rdata;
      rs    = s_axi_rresp;
      @(posedge core_clk);
      if (ar_hs) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask

  // One instruction through the sequencer model
  task automatic run_op(input nalf_pkg::nalf_req_t q, input logic [3:0] lag, output nalf_pkg::nalf_res_t y);
    cmd <= q;
    dly <= lag;
    go  <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    do @(negedge core_clk); while (got_valid !== 1'b1);
    y = got;
    @(posedge core_clk);
  endtask

  // Hang guard, well beyond the expected run
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    err_count = 0;
    cmp_count = 0;
    sys_rst = 1'b1;
    go = 1'b0;
    dly = 4'h0;
    cmd = '0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    axi_rd(nalf_pkg::ADDR_PSW, rd, rsp);
    chk(rd, 32'h00000000);
    axi_wr(nalf_pkg::ADDR_PSW, 32'hffffffff, rsp);
    axi_rd(nalf_pkg::ADDR_PSW, rd, rsp);
    chk(rd, 32'h0000000f);
    axi_wr(8'h08, 32'h0000005a, rsp);
    chk(32'(rsp), 32'(nalf_pkg::RESP_SLV));
    axi_rd(8'h08, rd, rsp);
    chk({rd[29:0], rsp}, {30'h0, nalf_pkg::RESP_SLV});
    for (int i = 0; i < 28; i++) begin
      axi_wr(nalf_pkg::ADDR_PSW, {28'h0, vecs[i][15:12]}, rsp);
      r.op  = nalf_pkg::nalf_op_t'(vecs[i][27:24]);
      r.opa = vecs[i][23:20];
      r.opb = vecs[i][19:16];
      run_op(r, 4'(i % 4), o);
      if (vecs[i][1]) chk(32'(o.data), 32'(vecs[i][11:8]));
      chk({30'h0, o.wb, o.skip}, {30'h0, vecs[i][1:0]});
      axi_rd(nalf_pkg::ADDR_PSW, rd, rsp);
      chk(rd, {28'h0, vecs[i][7:4]});
    end
    // Status register is read-only and shows the last result
    axi_wr(nalf_pkg::ADDR_STAT, 32'h000000ff, rsp);
    axi_rd(nalf_pkg::ADDR_STAT, rd, rsp);
    chk({rd[29:0], rsp}, {30'h21, nalf_pkg::RESP_OKAY});
    tally_and_finish();
  end
endmodule
